/* sens_defines.svh */
// Constants of the sensor SPI command block
`ifndef SENS_DEFINES_SVH
`define SENS_DEFINES_SVH
`define SENS_CLK_PERIOD_NS 10
`define SENS_NS_PER_US     1000
`define SENS_MEAS_TIME_US  2299
`define SENS_OP_WR         8'h87
`define SENS_OP_RR         8'h8E
`define SENS_OP_RO         8'hB0
`define SENS_OP_RST        8'hC3
`define SENS_OP_SM_HI      4'hA
`define SENS_CRC_POLY      8'h2F
`define SENS_CRC_INIT      8'hFF
`define SENS_CRC_OK        8'h00
`define SENS_SPI_IDLE      3'h4
`define SENS_LAST_BIT      3'h7
`define SENS_BYTE_CMD      5'h00
`define SENS_BYTE_CTL2     5'h01
`define SENS_BYTE_CTL3     5'h02
`define SENS_BYTE_MAX      5'h1F
`define SENS_NWORDS        4'h9
`define SENS_M_HI          7
`define SENS_M_LO          1
`define SENS_M_TEMP        6
`define SENS_M_AMB         5
`define SENS_M_DC          4
`define SENS_M_LEDA        3
`define SENS_M_LEDB        2
`define SENS_M_BA          1
`define SENS_M_BB          0
`define SENS_A_HI          7
`define SENS_A_LO          4
`define SENS_P1_POS        3
`define SENS_P0_POS        2
`define SENS_STAT_PAD      6'h00
`define SENS_FILL          8'h00
`endif

/* sens_pkg.sv */
// Types shared by the sensor SPI command block
`default_nettype none
package sens_pkg;
  typedef logic [15:0]      sens_word_t;
  typedef logic [15:0][7:0] sens_regs_t;
  // SPI pins as driven by the master
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sens_spi_s;
  // Measurement results, word 0 (temperature) in the low bits
  typedef struct packed {
    sens_word_t dc_post_b;
    sens_word_t dc_post_a;
    sens_word_t burst_b;
    sens_word_t burst_a;
    sens_word_t dc_pre_b;
    sens_word_t dc_pre_a;
    sens_word_t amb_d;
    sens_word_t amb_c;
    sens_word_t temp;
  } sens_meas_s;
  typedef enum logic [2:0] {
    SENS_CMD_NONE,
    SENS_CMD_SM,
    SENS_CMD_RO,
    SENS_CMD_WR,
    SENS_CMD_RR,
    SENS_CMD_RST
  } sens_cmd_e;
endpackage
`default_nettype wire

/* sens_spi_readout.sv */
// SPI command interpreter and read-out frame of the sensor interface
`timescale 1ns/100ps
`default_nettype none
`include "sens_defines.svh"
// Functional notes
// [RQ1] Burst words A then B follow, MSB first, if selected and LED set
// [RQ2] Post-burst DC words A then B follow, MSB first, if DC selected
// [RQ3] One CRC byte always closes every output frame
// [RQ4] Disabled words are dropped, later bytes move up, no padding
// [RQ5] Master runs CRC over whole frame, nonzero means discard
// [RQ6] Extra clocks after start command shift stored data out
// [RQ7] Data registers are cleared when a read-out completes
// [RQ8] Combined start command executes only when chip select rises
// [RQ9] Chip select rise drops ready, ready returns after measure time
// [RQ10] Master holds chip select low until whole frame is out
// [RQ11] Read-out command only after ready; device sends stored data
// [RQ12] Sixteen 8-bit registers, written and read by command
// [RQ13] Write: opcode, data, then address, odd, even, two zeros
// [RQ14] Bad parity leaves registers and sets status bit 7
// [RQ15] Invalid flag is returned as status byte of next command
// [RQ16] Even parity is XOR, odd parity XNOR over twelve bits
// [RQ17] Register read returns status, opcode echo, register data
// [RQ18] Write and read take three bytes, others take two
// [RQ19] While measuring, only chip reset command is accepted
// [RQ20] CRC byte makes CRC over whole frame come out zero
module sens_spi_readout #(
  parameter int unsigned MEAS_CYCLES =
    (`SENS_MEAS_TIME_US * `SENS_NS_PER_US) / `SENS_CLK_PERIOD_NS
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 ce,
  input  wire sens_pkg::sens_spi_s  spi_in,
  output logic                      spi_miso,
  output logic                      spi_miso_oe,
  output logic                      data_ready_pin,
  input  wire logic                 amb_c_en,
  input  wire logic                 amb_d_en,
  input  wire sens_pkg::sens_meas_s meas_in,
  output logic                      meas_start,
  output logic [6:0]                meas_sel,
  output logic [7:0]                meas_opts,
  output sens_pkg::sens_regs_t      user_regs
);
  import sens_pkg::*;

  // CRC step over one byte, MSB first
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? `SENS_CRC_POLY : 8'h00);
    end
    return r;
  endfunction

  // Words present in the frame for a selection
  function automatic logic [8:0] mask_of(input logic [6:0] m,
                                         input logic       c_en,
                                         input logic       d_en);
    mask_of = {m[`SENS_M_DC], m[`SENS_M_DC],
               m[`SENS_M_BB] & m[`SENS_M_LEDB],
               m[`SENS_M_BA] & m[`SENS_M_LEDA],
               m[`SENS_M_DC], m[`SENS_M_DC],
               m[`SENS_M_AMB] & d_en, m[`SENS_M_AMB] & c_en,
               m[`SENS_M_TEMP]};
  endfunction

  // First present word at or after an index, word count if none
  function automatic logic [3:0] next_en(input logic [8:0] m,
                                         input logic [3:0] from);
    next_en = `SENS_NWORDS;
    for (int i = `SENS_NWORDS - 1; i >= 0; i--) begin
      if (m[i] && (4'(i) >= from)) next_en = 4'(i);
    end
  endfunction

  sens_spi_s        s1_q, s2_q, s3_q;
  logic             cs_fall, cs_rise, sck_rise, sck_fall, byte_end;
  logic [2:0]       bit_q;
  logic [4:0]       byte_q;
  logic [7:0]       rx_q, rx_byte;
  logic             at_cmd, at_ctl2, at_ctl3;
  sens_cmd_e        cmd_rx, cmd_q;
  logic             acc_rx, acc_q;
  logic [7:0]       opc_q, ctl2_q;
  logic [3:0]       wr_addr;
  logic             par_even, wr_ok, is_wr, wr_bad;
  logic             sm_ok, sm_bad, rej, rst_go;
  logic             inv_d, inv_q;
  logic             sm_pend_q, meas_go, meas_end;
  logic             busy_q, dr_q, dvalid_q;
  logic [31:0]      cnt_q;
  logic [8:0]       mask_q;
  sens_regs_t       regs_q;
  logic [8:0][15:0] data_q;
  logic             st_start, st_now, frm_lsb, frm_end;
  logic [3:0]       frm_wp, wp_q;
  logic             lsb_q, strm_q;
  logic [7:0]       crc_q, frm_crc, frm_byte;
  logic [15:0]      frm_word;
  logic [7:0]       tx_next, sh_q, nxt_q, status;
  logic             load_q;

  // Two-stage pin synchronisers plus one stage for edge detection
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= `SENS_SPI_IDLE;
      s2_q <= `SENS_SPI_IDLE;
      s3_q <= `SENS_SPI_IDLE;
    end else if (ce) begin
      s1_q <= spi_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Edges of chip select and serial clock, mode 0
  assign cs_fall  = s3_q.cs_n & ~s2_q.cs_n;
  assign cs_rise  = ~s3_q.cs_n & s2_q.cs_n;
  assign sck_rise = ~s2_q.cs_n & ~s3_q.sck & s2_q.sck;
  assign sck_fall = ~s2_q.cs_n & s3_q.sck & ~s2_q.sck;
  assign byte_end = sck_rise & (bit_q == `SENS_LAST_BIT);
  assign rx_byte  = {rx_q[6:0], s2_q.mosi};

  // Bit and byte counters, MOSI shift-in
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_q  <= '0;
      byte_q <= '0;
      rx_q   <= '0;
    end else if (ce) begin
      if (cs_fall) begin
        bit_q  <= '0;
        byte_q <= '0;
      end else if (sck_rise) begin
        bit_q <= bit_q + 3'h1;
        rx_q  <= rx_byte;
        if (byte_end && byte_q != `SENS_BYTE_MAX) begin
          byte_q <= byte_q + 5'h01;
        end
      end
    end
  end

  // Position of the byte just received
  assign at_cmd  = byte_end & (byte_q == `SENS_BYTE_CMD);
  assign at_ctl2 = byte_end & (byte_q == `SENS_BYTE_CTL2);
  assign at_ctl3 = byte_end & (byte_q == `SENS_BYTE_CTL3);

  // Opcode decode
  assign cmd_rx = (rx_byte == `SENS_OP_WR)  ? SENS_CMD_WR  :
                  (rx_byte == `SENS_OP_RR)  ? SENS_CMD_RR  :
                  (rx_byte == `SENS_OP_RO)  ? SENS_CMD_RO  :
                  (rx_byte == `SENS_OP_RST) ? SENS_CMD_RST :
                  (rx_byte[7:4] == `SENS_OP_SM_HI) ? SENS_CMD_SM :
                  SENS_CMD_NONE;
  // [RQ19] busy refuses commands
  assign acc_rx = ~busy_q | (cmd_rx == SENS_CMD_RST);
  assign rej    = at_cmd & ~acc_rx;

  // Command and control byte capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q  <= SENS_CMD_NONE;
      acc_q  <= 1'b0;
      opc_q  <= '0;
      ctl2_q <= '0;
    end else if (ce) begin
      if (cs_fall) begin
        cmd_q <= SENS_CMD_NONE;
      end else if (at_cmd) begin
        cmd_q <= cmd_rx;
        acc_q <= acc_rx;
        opc_q <= rx_byte;
      end
      if (at_ctl2) begin
        ctl2_q <= rx_byte;
      end
    end
  end

  // [RQ16] parity recomputed locally
  assign par_even = ^{ctl2_q, rx_byte[`SENS_A_HI:`SENS_A_LO]};
  // [RQ13] third byte layout
  assign wr_addr = rx_byte[`SENS_A_HI:`SENS_A_LO];
  assign wr_ok   = (rx_byte[`SENS_P0_POS] == par_even) &
                   (rx_byte[`SENS_P1_POS] == ~par_even);
  // [RQ18] write completes on third byte
  assign is_wr   = at_ctl3 & acc_q & (cmd_q == SENS_CMD_WR);
  assign wr_bad  = is_wr & ~wr_ok;
  // Start command carries even parity over its select bits
  assign sm_ok   = ~^rx_byte;
  assign sm_bad  = at_ctl2 & acc_q & (cmd_q == SENS_CMD_SM) & ~sm_ok;
  // [RQ18] short commands act after two bytes
  assign rst_go  = cs_rise & (cmd_q == SENS_CMD_RST) &
                   (byte_q >= `SENS_BYTE_CTL3);

  // [RQ12] register write path
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regs_q <= '0;
    end else if (ce) begin
      if (rst_go) begin
        regs_q <= '0;
      // [RQ14] write only on good parity
      end else if (is_wr && wr_ok) begin
        regs_q[wr_addr] <= ctl2_q;
      end
    end
  end

  // [RQ14] invalid flag, a new error wins over the read clear
  assign inv_d = wr_bad | sm_bad | rej |
                 (inv_q & ~cs_fall & ~rst_go);

  // Invalid flag and pending start command
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inv_q     <= 1'b0;
      sm_pend_q <= 1'b0;
    end else if (ce) begin
      inv_q <= inv_d;
      if (cs_fall || cs_rise) begin
        sm_pend_q <= 1'b0;
      end else if (at_ctl2 && acc_q && cmd_q == SENS_CMD_SM) begin
        sm_pend_q <= sm_ok;
      end
    end
  end

  // [RQ8] start deferred to chip select rise
  assign meas_go  = cs_rise & sm_pend_q;
  assign meas_end = busy_q & (cnt_q == '0) & ~rst_go;

  // [RQ9] measurement timer and ready pin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy_q     <= 1'b0;
      dr_q       <= 1'b0;
      cnt_q      <= '0;
      mask_q     <= '0;
      meas_start <= 1'b0;
      meas_sel   <= '0;
      meas_opts  <= '0;
    end else if (ce) begin
      meas_start <= meas_go;
      if (rst_go) begin
        busy_q <= 1'b0;
        dr_q   <= 1'b0;
      end else if (meas_go) begin
        busy_q    <= 1'b1;
        dr_q      <= 1'b0;
        cnt_q     <= MEAS_CYCLES - 1;
        mask_q    <= mask_of(ctl2_q[`SENS_M_HI:`SENS_M_LO],
                             amb_c_en, amb_d_en);
        meas_sel  <= ctl2_q[`SENS_M_HI:`SENS_M_LO];
        meas_opts <= opc_q;
      end else if (meas_end) begin
        busy_q <= 1'b0;
        dr_q   <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

  // Result store, emptied after each read-out
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      data_q   <= '0;
      dvalid_q <= 1'b0;
    end else if (ce) begin
      // [RQ7] clear after read-out
      if (rst_go || frm_end) begin
        data_q   <= '0;
        dvalid_q <= 1'b0;
      end else if (meas_end) begin
        data_q   <= meas_in;
        dvalid_q <= 1'b1;
      end
    end
  end

  // [RQ6] [RQ11] read-out begins with byte 3
  assign st_start = at_ctl2 & acc_q & dvalid_q & dr_q &
                    ((cmd_q == SENS_CMD_SM) | (cmd_q == SENS_CMD_RO));
  assign st_now   = byte_end & (st_start | strm_q);
  // [RQ4] skip words not selected
  assign frm_wp   = st_start ? next_en(mask_q, 4'h0) : wp_q;
  assign frm_lsb  = ~st_start & lsb_q;
  assign frm_crc  = st_start ? `SENS_CRC_INIT : crc_q;
  assign frm_end  = st_now & (frm_wp == `SENS_NWORDS);
  assign frm_word = (frm_wp < `SENS_NWORDS) ? data_q[frm_wp] : '0;
  // [RQ1] [RQ2] [RQ3] MSB byte, LSB byte, CRC last
  assign frm_byte = frm_end ? frm_crc :
                    (frm_lsb ? frm_word[7:0] : frm_word[15:8]);

  // Frame walker and running CRC
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strm_q <= 1'b0;
      wp_q   <= '0;
      lsb_q  <= 1'b0;
      crc_q  <= `SENS_CRC_INIT;
    end else if (ce) begin
      if (cs_rise || cs_fall) begin
        strm_q <= 1'b0;
      end else if (st_now) begin
        strm_q <= ~frm_end;
        // [RQ20] CRC over frame bytes
        crc_q  <= crc_byte(frm_crc, frm_byte);
        lsb_q  <= ~frm_lsb;
        wp_q   <= frm_lsb ? next_en(mask_q, frm_wp + 4'h1) : frm_wp;
      end
    end
  end

  // [RQ15] [RQ17] status first, echo second, register third
  assign status  = {inv_q, `SENS_STAT_PAD, dr_q};
  assign tx_next = at_cmd ? rx_byte :
                   st_now ? frm_byte :
                   (at_ctl2 && acc_q && cmd_q == SENS_CMD_RR) ?
                   regs_q[rx_byte[`SENS_A_HI:`SENS_A_LO]] : `SENS_FILL;

  // MISO shifter, loads on the falling edge after a byte
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sh_q   <= '0;
      nxt_q  <= '0;
      load_q <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        sh_q   <= status;
        load_q <= 1'b0;
      end else if (byte_end) begin
        nxt_q  <= tx_next;
        load_q <= 1'b1;
      end else if (sck_fall) begin
        sh_q   <= load_q ? nxt_q : {sh_q[6:0], 1'b0};
        load_q <= 1'b0;
      end
    end
  end

  // Output drive
  assign spi_miso       = sh_q[7];
  assign spi_miso_oe    = ~s2_q.cs_n;
  assign data_ready_pin = dr_q;
  assign user_regs      = regs_q;

  // Checks on the design's own behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_meas_run;
    meas_go ##1 (!dr_q && busy_q);
  endsequence

  sequence s_flag_out;
    (inv_q && cs_fall) ##1 sh_q[7];
  endsequence

  chk_crc_closes: assert property ( // [RQ20]
    frm_end |-> crc_byte(frm_crc, frm_byte) == `SENS_CRC_OK)
    else $error("frame CRC does not close to zero");
  chk_wr_commit: assert property ( // [RQ14]
    ce && is_wr && wr_ok |=> regs_q[$past(wr_addr)] == $past(ctl2_q))
    else $error("good write not stored");
  chk_wr_keep: assert property ( // [RQ14]
    ce && wr_bad |=> $stable(regs_q) && inv_q)
    else $error("bad parity write changed registers");
  chk_flag_report: assert property ( // [RQ15]
    ce && inv_q && cs_fall |-> s_flag_out)
    else $error("invalid flag not in status byte");
  chk_dr_drop: assert property ( // [RQ9]
    ce && meas_go |-> s_meas_run)
    else $error("ready not dropped at start");
  chk_dr_rise: assert property ( // [RQ9]
    ce && meas_end |=> dr_q && dvalid_q && !busy_q)
    else $error("ready not raised at end of measure");
  chk_start_on_cs: assert property ( // [RQ8]
    $rose(busy_q) |-> $past(cs_rise) && meas_start)
    else $error("measurement started without chip select rise");
  chk_data_clear: assert property ( // [RQ7]
    ce && frm_end |=> !dvalid_q && data_q == '0)
    else $error("data not cleared after read-out");
  chk_busy_reject: assert property ( // [RQ19]
    ce && rej |=> !acc_q && inv_q)
    else $error("command accepted while busy");
  chk_crc_last: assert property ( // [RQ3]
    ce && frm_end |=> !strm_q ##1 !st_now)
    else $error("frame continued after CRC");
endmodule
`default_nettype wire

/* sens_spi_master.sv */
// SPI master model that drives the sensor command link
`timescale 1ns/100ps
`default_nettype none
module sens_spi_master (
  output var sens_pkg::sens_spi_s spi,
  input  wire logic               miso_w
);
  import sens_pkg::*;
  // Half of the 125 ns link clock period
  localparam realtime HALF = 62.5;
  logic [7:0] tx_buf [32];
  logic [7:0] rx_buf [32];
  // Link idles with chip select high and the clock low
  initial begin
    spi = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
  end
  // chip select held
  // Mode 0 bytes, MSB first; chip select stays low at the end
  task automatic frame(input int n);
    int i;
    int k;
    #(2 * HALF);
    spi.cs_n = 1'b0;
    for (i = 0; i < n; i++) begin
      for (k = 7; k >= 0; k--) begin
        spi.mosi = tx_buf[i][k];
        #(HALF);
        rx_buf[i][k] = miso_w;
        spi.sck = 1'b1;
        #(HALF);
        spi.sck = 1'b0;
      end
    end
  endtask
  // Ends the frame; MOSI no longer holds its last bit
  task automatic release_cs();
    #(HALF);
    spi.cs_n = 1'b1;
    spi.mosi = ~spi.mosi;
  endtask
endmodule
`default_nettype wire

/* sensor_spi_readout_and_regs_tb_top.sv */
// Self-checking bench of the sensor SPI command interpreter
`timescale 1ns/100ps
`default_nettype none
`include "sens_defines.svh"
module sensor_spi_readout_and_regs_tb_top;
  import sens_pkg::*;
  localparam int MC = 2000;
  logic        clk_sys;
  logic        arst_n;
  logic        ce;
  logic        amb_c_en;
  logic        amb_d_en;
  sens_meas_s  meas_in;
  sens_spi_s   spi;
  logic        spi_miso;
  logic        spi_miso_oe;
  logic        miso_w;
  logic        data_ready_pin;
  logic        meas_start;
  logic [6:0]  meas_sel;
  logic [7:0]  meas_opts;
  sens_regs_t  user_regs;
  sens_regs_t  exp_regs;
  logic [7:0]  exp_f [32];
  int          exp_n;
  int          since;
  int          failures;
  int          checked;
  logic [31:0] rng;
  logic        rdy;

  sens_spi_readout #(.MEAS_CYCLES(MC)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .spi_in(spi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .data_ready_pin(data_ready_pin), .amb_c_en(amb_c_en),
    .amb_d_en(amb_d_en), .meas_in(meas_in), .meas_start(meas_start),
    .meas_sel(meas_sel), .meas_opts(meas_opts), .user_regs(user_regs));
  sens_spi_master master (.spi(spi), .miso_w(miso_w));
  // Released MISO toggles so a stale bit never reads as valid
  assign miso_w = spi_miso_oe ? spi_miso : clk_sys;

  // Cycles from the start pulse until results are ready
  always @(posedge clk_sys) begin
    if (meas_start === 1'b1) begin
      since <= 0;
    end else if (data_ready_pin !== 1'b1) begin
      since <= since + 1;
    end
  end

  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    int         k;
    x = c ^ b;
    for (k = 0; k < 8; k++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ `SENS_CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // One command; status and opcode echo checked on every one
  task automatic xfer(input logic [7:0] st, input logic [7:0] b0,
                      input logic [7:0] b1, input logic [7:0] b2,
                      input int n, input bit keep);
    master.tx_buf = '{default: 8'h00};
    master.tx_buf[0] = b0;
    master.tx_buf[1] = b1;
    master.tx_buf[2] = b2;
    master.frame(n);
    check("status", master.rx_buf[0], st);
    check("echo", master.rx_buf[1], b0);
    if (!keep) begin
      master.release_cs();
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d,
                        input bit bad, input logic [7:0] st);
    logic p0;
    p0 = ^{d, a};
    xfer(st, `SENS_OP_WR, d, {a, ~p0 ^ bad, p0, 2'b00}, 3, 1'b0);
    check("wr_byte3", master.rx_buf[2], `SENS_FILL);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] st,
                        input logic [7:0] d);
    xfer(st, `SENS_OP_RR, {a, 4'h0}, 8'h00, 3, 1'b0);
    check("rd_data", master.rx_buf[2], d);
  endtask
  // Expected frame from the current inputs and a select pattern
  task automatic build(input logic [6:0] ms);
    logic [15:0] w [9];
    logic [8:0]  on;
    logic [7:0]  c;
    int          i;
    w = '{meas_in.temp, meas_in.amb_c, meas_in.amb_d,
          meas_in.dc_pre_a, meas_in.dc_pre_b, meas_in.burst_a,
          meas_in.burst_b, meas_in.dc_post_a, meas_in.dc_post_b};
    on = {ms[4], ms[4], ms[0] & ms[2], ms[1] & ms[3], ms[4], ms[4],
          ms[5] & amb_d_en, ms[5] & amb_c_en, ms[6]};
    exp_n = 0;
    c = `SENS_CRC_INIT;
    for (i = 0; i < 9; i++) begin
      if (on[i]) begin
        exp_f[exp_n] = w[i][15:8];
        exp_f[exp_n + 1] = w[i][7:0];
        c = crc8(crc8(c, w[i][15:8]), w[i][7:0]);
        exp_n += 2;
      end
    end
    exp_f[exp_n] = c;
    exp_n++;
  endtask
  task automatic cmp_frame(input bit zero);
    logic [7:0] c;
    int         i;
    c = `SENS_CRC_INIT;
    for (i = 0; i < exp_n; i++) begin
      check("frame", master.rx_buf[i + 2], zero ? 8'h00 : exp_f[i]);
      c = crc8(c, master.rx_buf[i + 2]);
    end
    if (!zero) begin
      check("crc_all", c, `SENS_CRC_OK);
    end
  endtask
  task automatic set_inputs();
    logic [159:0] r;
    r = {nxt(), nxt(), nxt(), nxt(), nxt()};
    @(posedge clk_sys);
    meas_in <= r[143:0];
    amb_c_en <= r[150];
    amb_d_en <= r[151];
    // Let the new values settle before anyone reads them back
    #1;
  endtask
  task automatic wait_pulse(input logic [6:0] ms);
    int n;
    n = 0;
    while (meas_start !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("start", meas_start, 1'b1);
    check("sel", meas_sel, ms);
    check("opts", meas_opts, {`SENS_OP_SM_HI, 4'h3});
    check("ready_low", data_ready_pin, 1'b0);
    rdy = 1'b0;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (data_ready_pin !== 1'b1 && n < 3 * MC) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("meas_time", since, MC - 1);
    rdy = 1'b1;
  endtask
  // Start command, reading the stored frame with extra clocks
  task automatic measure(input logic [6:0] ms, input int n);
    xfer({7'h00, rdy}, {`SENS_OP_SM_HI, 4'h3}, {ms, ^ms}, 8'h00, n, 1);
    if (n > 2) begin
      cmp_frame(1'b0);
    end
    check("ready_hold", data_ready_pin, rdy);
    master.release_cs();
    wait_pulse(ms);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever begin
      #5 clk_sys = ~clk_sys;
    end
  end
  // Watchdog: the tests need under half of this span
  initial begin
    #950000;
    failures++;
    wrap_up();
  end
  initial begin
    logic [31:0] r;
    logic [3:0]  a;
    logic [6:0]  sel;
    logic [6:0]  prev;
    int          i;
    rng = 32'h6E8CEC33;
    arst_n = 1'b0;
    ce = 1'b1;
    amb_c_en = 1'b0;
    amb_d_en = 1'b0;
    meas_in = '0;
    exp_regs = '0;
    rdy = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    check("rst_ready", data_ready_pin, 1'b0);
    check("rst_oe", spi_miso_oe, 1'b0);
    check("rst_regs", |user_regs, 1'b0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    $display("Test reset done");
    for (i = 0; i < 8; i++) begin
      r = nxt();
      a = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : r[11:8];
      wr_reg(a, r[7:0], 1'b0, 8'h00);
      exp_regs[a] = r[7:0];
      rd_reg(a, 8'h00, exp_regs[a]);
      check("reg_port", user_regs[a], exp_regs[a]);
    end
    wr_reg(4'h6, ~exp_regs[6], 1'b1, 8'h00);
    rd_reg(4'h6, 8'h80, exp_regs[6]);
    rd_reg(4'h6, 8'h00, exp_regs[6]);
    $display("Test registers done");
    set_inputs();
    build(7'h7F);
    measure(7'h7F, 2);
    wr_reg(4'h6, ~exp_regs[6], 1'b0, 8'h00);
    wait_rdy();
    rd_reg(4'h6, 8'h81, exp_regs[6]);
    xfer(8'h01, `SENS_OP_RO, 8'h00, 8'h00, exp_n + 2, 1'b0);
    cmp_frame(1'b0);
    xfer(8'h01, `SENS_OP_RO, 8'h00, 8'h00, exp_n + 2, 1'b0);
    cmp_frame(1'b1);
    $display("Test separate done");
    prev = 7'h00;
    for (i = 0; i < 6; i++) begin
      r = nxt();
      sel = (i == 1) ? 7'h00 : (i == 2) ? 7'h7F : r[6:0];
      build(prev);
      set_inputs();
      measure(sel, (i == 0) ? 2 : exp_n + 2);
      wait_rdy();
      prev = sel;
    end
    $display("Test combined done");
    // chip reset still taken while measuring
    measure(7'h00, 2);
    xfer(8'h00, `SENS_OP_RST, 8'h00, 8'h00, 2, 1'b0);
    repeat (MC + 20) @(posedge clk_sys);
    #1;
    check("rst_cmd_regs", |user_regs, 1'b0);
    check("rst_cmd_ready", data_ready_pin, 1'b0);
    rd_reg(4'h6, 8'h00, 8'h00);
    // start command with bad parity is flagged, not run
    xfer(8'h00, {`SENS_OP_SM_HI, 4'h3}, 8'h01, 8'h00, 2, 1'b0);
    rd_reg(4'h6, 8'h80, 8'h00);
    rd_reg(4'h6, 8'h00, 8'h00);
    $display("Test chip reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
